// file: verilog/remote_i2c_address_remap.sv
// Local design decision: the APB interface to the registers.
`default_nettype none

// Function
// - physical slot holds writable 7-bit address in bits 7:1; bit 0 reads zero.
// - transaction aimed at alias N goes out carrying slot N physical address when no lower slot holds the same alias.
// - alias slot holds 7-bit compare value in bits 7:1, reset zero.
// - an alias of zero matches nothing, so that slot stays disabled.

module remote_i2c_address_remap
  import remap_pkg::*;
#(
  parameter int unsigned SLOTS = SLOT_COUNT
) (
  input  wire logic        pclk,      // bus clock, 250 MHz
  input  wire logic        presetn,   // async reset, active low
  input  wire logic        psel,      // apb select
  input  wire logic        penable,   // apb access phase
  input  wire logic        pwrite,    // apb direction
  input  wire logic [7:0]  paddr,     // apb byte address
  input  wire logic [31:0] pwdata,    // apb write data
  input  wire logic [3:0]  pstrb,     // apb byte strobes
  output logic      [31:0] prdata,    // apb read data
  output logic             pready,    // apb ready
  output logic             pslverr,   // apb error on unmapped address
  input  wire remap_req_s  req,       // address phase from local controller
  output remap_rsp_s       fwd        // address phase toward control channel
);

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  function automatic reg_dec_s decode_addr(input logic [7:0] a);
    reg_dec_s d;
    logic [5:0] idx;
    d   = '0;
    idx = a[7:2];
    if (a[1:0] == 2'b00) begin
      if ((idx >= PHYS_ADDR_0_IDX) && (idx <= PHYS_ADDR_7_IDX)) begin
        d.phys = 1'b1;
        d.slot = 3'(idx - PHYS_ADDR_0_IDX);
      end else if ((idx >= ALIAS_ADDR_0_IDX) && (idx <= ALIAS_ADDR_7_IDX)) begin
        d.alias_hit = 1'b1;
        d.slot      = 3'(idx - ALIAS_ADDR_0_IDX);
      end
    end
    return d;
  endfunction : decode_addr

  // read view of a slot field: field in 7:1, bit 0 and upper bits zero
  function automatic logic [31:0] field_word(input logic [6:0] f);
    return {24'h00_0000, f, 1'b0};
  endfunction : field_word

  reg_dec_s dec;
  logic     access;
  logic     done;
  logic     pready_r;

  assign dec    = decode_addr(paddr);
  assign access = psel && penable;
  assign done   = access && pready_r;

  // ----------------------------------------------------------------
  // apb slave: one wait state, every answer registered
  // ----------------------------------------------------------------
  logic        pready_nxt;
  logic        pslverr_r;
  logic        pslverr_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;

  logic [SLOTS-1:0][6:0] phys_r;
  logic [SLOTS-1:0][6:0] phys_nxt;
  logic [SLOTS-1:0][6:0] alias_r;
  logic [SLOTS-1:0][6:0] alias_nxt;

  always_comb begin
    pready_nxt  = access && !pready_r;
    pslverr_nxt = 1'b0;
    prdata_nxt  = PRDATA_RST;
    if (access && !pready_r) begin
      pslverr_nxt = !(dec.phys || dec.alias_hit);
      if (!pwrite) begin
        if (dec.phys) begin
          prdata_nxt = field_word(phys_r[dec.slot]);
        end else if (dec.alias_hit) begin
          prdata_nxt = field_word(alias_r[dec.slot]);
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= PRDATA_RST;
    end else begin
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r  <= prdata_nxt;
    end
  end

  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign prdata  = prdata_r;

  // ----------------------------------------------------------------
  // slot registers
  // ----------------------------------------------------------------
  // bit 0 is never stored, so it cannot read back as anything but zero
  always_comb begin
    phys_nxt  = phys_r;
    alias_nxt = alias_r;
    if (done && pwrite && pstrb[0]) begin
      if (dec.phys) begin
        phys_nxt[dec.slot] = pwdata[FIELD_MSB:FIELD_LSB];
      end else if (dec.alias_hit) begin
        alias_nxt[dec.slot] = pwdata[FIELD_MSB:FIELD_LSB];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < SLOTS; i++) begin
        phys_r[i]  <= SLOT_ADDR_RST;
        alias_r[i] <= ALIAS_OFF;
      end
    end else begin
      phys_r  <= phys_nxt;
      alias_r <= alias_nxt;
    end
  end

  // ----------------------------------------------------------------
  // remap path
  // ----------------------------------------------------------------
  logic       dec_hit;
  logic [2:0] dec_slot;
  logic [6:0] dec_addr;

  alias_decoder #(
    .SLOTS      (SLOTS)
  ) u_alias_decoder (
    .alias_addr (alias_r),
    .phys_addr  (phys_r),
    .addr_in    (req.addr),
    .hit        (dec_hit),
    .slot       (dec_slot),
    .addr_out   (dec_addr)
  );

  remap_rsp_s fwd_r;
  remap_rsp_s fwd_nxt;

  // one register stage keeps the output glitch free toward the channel framer
  always_comb begin
    fwd_nxt = '0;
    if (req.valid) begin
      fwd_nxt.valid = 1'b1;
      fwd_nxt.hit   = dec_hit;
      fwd_nxt.slot  = dec_slot;
      fwd_nxt.addr  = dec_addr;
      fwd_nxt.rnw   = req.rnw;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_r <= '0;
    end else begin
      fwd_r <= fwd_nxt;
    end
  end

  assign fwd = fwd_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence apb_setup_s;
    psel && !penable;
  endsequence

  sequence apb_first_access_s;
    psel && penable && !pready_r;
  endsequence

  sequence read_done_s;
    psel && penable && pready_r && !pwrite && !pslverr_r;
  endsequence

  property wait_state_p;
    @(posedge pclk) disable iff (!presetn)
      apb_setup_s ##1 apb_first_access_s |=> pready_r;
  endproperty

  apb_wait_a: assert property (wait_state_p)
    else $error("apb answer not given after one wait state");

  apb_ready_pulse_a: assert property (
    @(posedge pclk) disable iff (!presetn)
      pready_r |=> !pready_r)
    else $error("pready held longer than one cycle");

  read_bit0_a: assert property (
    @(posedge pclk) disable iff (!presetn)
      read_done_s |-> (prdata_r[31:8] == 24'h00_0000) && !prdata_r[0])
    else $error("reserved read bits not zero");

  phys_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
      done && pwrite && pstrb[0] && dec.phys
      |=> phys_r[$past(dec.slot)] == $past(pwdata[7:1]))
    else $error("physical slot write not stored");

  alias_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
      done && pwrite && pstrb[0] && dec.alias_hit
      |=> alias_r[$past(dec.slot)] == $past(pwdata[7:1]))
    else $error("alias slot write not stored");

  slot0_remap_a: assert property (
    @(posedge pclk) disable iff (!presetn)
      req.valid && (alias_r[0] != ALIAS_OFF) && (req.addr == alias_r[0])
      |=> fwd_r.valid && fwd_r.hit && (fwd_r.slot == 3'h0)
          && (fwd_r.addr == $past(phys_r[0])))
    else $error("alias of slot 0 not swapped for its physical address");

  zero_alias_a: assert property (
    @(posedge pclk) disable iff (!presetn)
      req.valid && (req.addr == ALIAS_OFF) |=> fwd_r.valid && !fwd_r.hit)
    else $error("zero address matched a disabled alias");

  miss_pass_a: assert property (
    @(posedge pclk) disable iff (!presetn)
      fwd_r.valid && !fwd_r.hit
      |-> (fwd_r.addr == $past(req.addr)) && (fwd_r.rnw == $past(req.rnw)))
    else $error("missed address was altered");

  fwd_strobe_a: assert property (
    @(posedge pclk) disable iff (!presetn)
      req.valid |=> fwd_r.valid ##1 (fwd_r.valid == $past(req.valid)))
    else $error("forward strobe not one cycle after request");

  // per-slot match vector kept apart from the decoder, for the checks below only
  logic [SLOTS-1:0] alias_match;

  always_comb begin
    for (int i = 0; i < SLOTS; i++) begin
      alias_match[i] = (alias_r[i] != ALIAS_OFF) && (alias_r[i] == req.addr);
    end
  end

  sequence phys_read_s;
    apb_first_access_s ##0 (!pwrite && dec.phys);
  endsequence

  sequence alias_read_s;
    apb_first_access_s ##0 (!pwrite && dec.alias_hit);
  endsequence

  idle_bus_quiet_a: assert property (
    @(posedge pclk) disable iff (!presetn)
      !pready_r |-> (prdata_r == PRDATA_RST) && !pslverr_r)
    else $error("read data or error shown outside a transfer");

  unmapped_error_a: assert property (
    @(posedge pclk) disable iff (!presetn)
      apb_first_access_s ##0 !(dec.phys || dec.alias_hit)
      |=> pready_r && pslverr_r && (prdata_r == PRDATA_RST))
    else $error("unmapped access not answered with an error");

  no_stray_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
      !(done && pwrite && pstrb[0] && !pslverr_r) |=> $stable(phys_r) && $stable(alias_r))
    else $error("slot register changed without a write");

  phys_read_a: assert property (
    @(posedge pclk) disable iff (!presetn)
      phys_read_s
      |=> pready_r && !pslverr_r && (prdata_r[7:1] == $past(phys_r[dec.slot])))
    else $error("physical slot read returned wrong value");

  alias_read_a: assert property (
    @(posedge pclk) disable iff (!presetn)
      alias_read_s
      |=> pready_r && !pslverr_r && (prdata_r[7:1] == $past(alias_r[dec.slot])))
    else $error("alias slot read returned wrong value");

  miss_untouched_a: assert property (
    @(posedge pclk) disable iff (!presetn)
      req.valid && (alias_match == '0)
      |=> fwd_r.valid && !fwd_r.hit && (fwd_r.slot == 3'h0)
          && (fwd_r.addr == $past(req.addr)))
    else $error("unmatched address was remapped");

  // lower slots win on duplicate aliases, so each check requires no lower match
  for (genvar k = 0; k < SLOTS; k++) begin : g_pair_chk
    localparam logic [SLOTS-1:0] LOWER = SLOTS'((1 << k) - 1);

    slot_pair_a: assert property (
      @(posedge pclk) disable iff (!presetn)
        req.valid && alias_match[k] && ((alias_match & LOWER) == '0)
        |=> fwd_r.valid && fwd_r.hit && (fwd_r.slot == 3'(k))
            && (fwd_r.addr == $past(phys_r[k])))
      else $error("matching alias not swapped for its paired address");
  end

endmodule : remote_i2c_address_remap

`default_nettype wire

// file: verilog/remap_pkg.sv
`default_nettype none

package remap_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int unsigned SLOT_COUNT   = 8;
  localparam int unsigned I2C_ADDR_W   = 7;
  localparam int unsigned SLOT_IDX_W   = 3;
  localparam int unsigned APB_ADDR_W   = 8;
  localparam int unsigned APB_DATA_W   = 32;
  localparam int unsigned REG_W        = 8;
  localparam int unsigned FIELD_LSB    = 1;
  localparam int unsigned FIELD_MSB    = 7;

  // ----------------------------------------------------------------
  // register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [5:0] PHYS_ADDR_0_IDX  = 6'h08;
  localparam logic [5:0] PHYS_ADDR_1_IDX  = 6'h09;
  localparam logic [5:0] PHYS_ADDR_2_IDX  = 6'h0A;
  localparam logic [5:0] PHYS_ADDR_3_IDX  = 6'h0B;
  localparam logic [5:0] PHYS_ADDR_4_IDX  = 6'h0C;
  localparam logic [5:0] PHYS_ADDR_5_IDX  = 6'h0D;
  localparam logic [5:0] PHYS_ADDR_6_IDX  = 6'h0E;
  localparam logic [5:0] PHYS_ADDR_7_IDX  = 6'h0F;
  localparam logic [5:0] ALIAS_ADDR_0_IDX = 6'h10;
  localparam logic [5:0] ALIAS_ADDR_1_IDX = 6'h11;
  localparam logic [5:0] ALIAS_ADDR_2_IDX = 6'h12;
  localparam logic [5:0] ALIAS_ADDR_3_IDX = 6'h13;
  localparam logic [5:0] ALIAS_ADDR_4_IDX = 6'h14;
  localparam logic [5:0] ALIAS_ADDR_5_IDX = 6'h15;
  localparam logic [5:0] ALIAS_ADDR_6_IDX = 6'h16;
  localparam logic [5:0] ALIAS_ADDR_7_IDX = 6'h17;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [6:0]  SLOT_ADDR_RST = 7'h00;
  localparam logic [6:0]  ALIAS_OFF     = 7'h00;
  localparam logic [31:0] PRDATA_RST    = 32'h0000_0000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       valid;   // one-cycle address-phase strobe
    logic [6:0] addr;    // 7-bit target address from local controller
    logic       rnw;     // i2c direction bit, passed through
  } remap_req_s;

  typedef struct packed {
    logic       valid;   // one-cycle strobe toward control channel
    logic       hit;     // address was an enabled alias and got swapped
    logic [2:0] slot;    // matching slot, zero on a miss
    logic [6:0] addr;    // address to forward
    logic       rnw;     // direction bit
  } remap_rsp_s;

  typedef struct packed {
    logic       phys;
    logic       alias_hit;
    logic [2:0] slot;
  } reg_dec_s;

endpackage : remap_pkg

`default_nettype wire

// file: verilog/alias_decoder.sv
`default_nettype none

module alias_decoder
  import remap_pkg::*;
#(
  parameter int unsigned SLOTS = SLOT_COUNT
) (
  input  wire logic [SLOTS-1:0][6:0] alias_addr,  // alias per slot
  input  wire logic [SLOTS-1:0][6:0] phys_addr,   // physical address per slot
  input  wire logic [6:0]            addr_in,     // incoming target address
  output logic                       hit,         // some enabled alias matched
  output logic [2:0]                 slot,        // lowest matching slot
  output logic [6:0]                 addr_out     // remapped or untouched address
);

  always_comb begin
    hit      = 1'b0;
    slot     = 3'h0;
    addr_out = addr_in;
    // descending scan so the lowest index wins on duplicate aliases
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if ((alias_addr[i] != ALIAS_OFF) && (alias_addr[i] == addr_in)) begin
        hit      = 1'b1;
        slot     = 3'(i);
        addr_out = phys_addr[i];
      end
    end
  end

endmodule : alias_decoder

`default_nettype wire

// file: dv/i2c_side_model.sv
`default_nettype none

module i2c_side_model
  import remap_pkg::*;
(
  input  wire logic       pclk,       // bus clock
  input  wire logic       presetn,    // async reset, active low
  input  wire logic       send,       // issue one address phase
  input  wire logic [6:0] send_addr,  // target address
  input  wire logic       send_rnw,   // direction bit
  output var  remap_req_s req         // toward the remapper
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // address phase driver
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req <= '0;
    end else if (send) begin
      req <= '{valid: 1'b1, addr: send_addr, rnw: send_rnw};
    end else begin
      // idle lines toggle so a stale address never matches by luck
      req <= '{valid: 1'b0, addr: ~req.addr, rnw: ~req.rnw};
    end
  end

endmodule : i2c_side_model

`default_nettype wire

// file: dv/remote_i2c_address_remap_test.sv
`default_nettype none

module remote_i2c_address_remap_test
  import remap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [31:0] d;
    logic        e;
    logic        rd;
  } rd_s;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, send, send_rnw;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic [6:0]  send_addr;
  remap_req_s  req;
  remap_rsp_s  fwd, fcur;
  rd_s         rcur;
  rd_s         rd_q[$];
  remap_rsp_s  fw_q[$];
  logic [6:0]  ph[8], al[8];
  logic [15:0] lf;
  int          mismatches, n_compared, cyc;

  remote_i2c_address_remap dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .req(req), .fwd(fwd));
  i2c_side_model ctrl_u (.pclk(pclk), .presetn(presetn), .send(send),
    .send_addr(send_addr), .send_rnw(send_rnw), .req(req));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction : rnd

  // descending scan so the lowest matching slot wins
  function automatic remap_rsp_s expect_fwd(input logic [6:0] a, input logic r);
    remap_rsp_s x;
    x = '{valid: 1'b1, hit: 1'b0, slot: 3'h0, addr: a, rnw: r};
    for (int n = 7; n >= 0; n--) begin
      if (al[n] != 7'h00 && al[n] == a) begin
        x.hit = 1'b1;
        x.slot = n[2:0];
        x.addr = ph[n];
      end
    end
    return x;
  endfunction : expect_fwd

  task cmp_val(input string what, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s exp %h got %h", what, e, g);
    end
  endtask : cmp_val

  task cmp_fwd(input remap_rsp_s e, input remap_rsp_s g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected fwd exp %h got %h", e, g);
    end
  endtask : cmp_fwd

  task wrap_up();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  // called just after a rising edge; returns one edge after the completing edge,
  // so psel is never cleared and set again in one time step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
           input logic [31:0] ed, input logic ee);
    rd_q.push_back('{d: ed, e: ee, rd: !w});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task wr(input logic [5:0] idx, input logic [31:0] d, input logic [3:0] s);
    if (s[0] && idx[5:3] == 3'b001) ph[idx[2:0]] = d[7:1];
    if (s[0] && idx[5:3] == 3'b010) al[idx[2:0]] = d[7:1];
    apb(1'b1, {idx, 2'b00}, d, s, 32'h0000_0000, 1'b0);
  endtask : wr

  task rd(input logic [5:0] idx);
    apb(1'b0, {idx, 2'b00}, {rnd(), rnd()}, 4'hf,
        {24'h00_0000, idx[4] ? al[idx[2:0]] : ph[idx[2:0]], 1'b0}, 1'b0);
  endtask : rd

  task issue(input logic [6:0] a);
    send <= 1'b1;
    send_addr <= a;
    send_rnw <= lf[0];
    fw_q.push_back(expect_fwd(a, lf[0]));
    void'(rnd());
    @(posedge pclk);
  endtask : issue

  // ----------------------------------------------------------------
  // monitors and timeout
  // ----------------------------------------------------------------
  // outputs are looked at mid-cycle, where the registered values have settled
  always @(negedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      wrap_up();
    end
    if (presetn === 1'b1 && pready === 1'b1) begin
      cmp_val("pready", 32'h0000_0001, 32'(rd_q.size() != 0));
      rcur = rd_q.pop_front();
      if (rcur.rd) cmp_val("prdata", rcur.d, prdata);
      cmp_val("pslverr", {31'h0000_0000, rcur.e}, {31'h0000_0000, pslverr});
    end
    if (presetn === 1'b1 && fwd.valid !== 1'b0) begin
      cmp_val("fwd count", 32'h0000_0001, 32'(fw_q.size() != 0));
      fcur = fw_q.pop_front();
      cmp_fwd(fcur, fwd);
    end
  end

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, send, send_rnw} = '0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    send_addr = 7'h00;
    lf = 16'h0034;
    cyc = 0;
    foreach (ph[i]) {ph[i], al[i]} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 8; i < 24; i++) rd(i[5:0]);
    apb(1'b0, 8'h00, 32'h0000_0000, 4'hf, 32'h0000_0000, 1'b1);
    apb(1'b0, 8'h21, 32'h0000_0000, 4'hf, 32'h0000_0000, 1'b1);
    $display("test reset_values done");
    for (int i = 8; i < 16; i++) wr(i[5:0], {rnd(), rnd()}, 4'hf);
    for (int i = 8; i < 16; i++) rd(i[5:0]);
    issue(7'h00);
    for (int i = 0; i < 8; i++) issue(ph[i]);
    send <= 1'b0;
    $display("test alias_off done");
    for (int i = 0; i < 8; i++)
      wr(6'h10 + 6'(i), {24'h00_00ff, 4'b1010, 3'(i), 1'b1}, 4'hf);
    wr(6'h10, 32'h0000_00fe, 4'he);
    for (int i = 16; i < 24; i++) rd(i[5:0]);
    for (int i = 7; i >= 0; i--) issue(al[i]);
    issue(7'h7f);
    send <= 1'b0;
    $display("test remap_all done");
    wr(6'h17, {24'h00_0000, al[2], 1'b0}, 4'hf);
    wr(6'h13, 32'h0000_0001, 4'hf);
    for (int i = 0; i < 24; i++) issue(lf[0] ? al[lf[3:1]] : lf[10:4]);
    send <= 1'b0;
    repeat (3) @(posedge pclk);
    cmp_val("pending", 32'h0000_0000, 32'(fw_q.size() + rd_q.size()));
    $display("test random_mix done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ph[i]) {ph[i], al[i]} = '0;
    @(posedge pclk);
    for (int i = 8; i < 24; i++) rd(i[5:0]);
    issue(7'h50);
    send <= 1'b0;
    repeat (3) @(posedge pclk);
    cmp_val("pending", 32'h0000_0000, 32'(fw_q.size() + rd_q.size()));
    $display("test mid_reset done");
    wrap_up();
  end

endmodule : remote_i2c_address_remap_test

`default_nettype wire
